// ### pkg/crf_pkg.sv
// Constants, types and helpers for the charge rationing and fault control block
package crf_pkg;
  localparam int CLK_NS = 5;
  // Auto-recovery wait before retesting faults
  localparam int T_CYCLE_NS = 1000;
  localparam int T_CYCLE_CYC = (T_CYCLE_NS / CLK_NS < 1) ? 1 : T_CYCLE_NS / CLK_NS;
  localparam int CYC_W = 16;
  localparam int CW = 16;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_THR1 = 8'h0C;
  localparam logic [7:0] A_THR2 = 8'h10;
  localparam logic [7:0] A_CHG = 8'h14;

  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_ACT_LSB = 2;
  localparam int CTRL_LATCH = 6;
  localparam int CMD_RST_LSB = 0;
  localparam int CMD_ECLR_LSB = 2;

  localparam logic [CW-1:0] THR_RST = 16'hFFFF;

  typedef enum logic [1:0] {
    ACT_REPORT = 2'h0,
    ACT_REPDIS = 2'h1,
    ACT_DISSLEEP = 2'h2,
    ACT_IGNORE = 2'h3
  } crf_act_t;

  localparam crf_act_t ACT_RST = ACT_REPDIS;

  // Gray along sleep -> active -> error; reached_flag_a sleep beside sleep
  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_ERROR = 2'h3,
    ST_RSLEEP = 2'h2
  } crf_pst_t;

  function automatic logic f_alerts(input crf_act_t a);
    return (a == ACT_REPORT) || (a == ACT_REPDIS);
  endfunction

  function automatic logic f_blocks(input crf_act_t a);
    return (a == ACT_REPDIS) || (a == ACT_DISSLEEP);
  endfunction
endpackage

// ### pkg/crf_port_if.sv
// Per-port link between the control core, fault classifier and recovery sequencer
`timescale 1ns/100ps
interface crf_port_if;
  logic port_power_request;
  logic in_error;
  logic latch_sel;
  logic err_clear;
  logic retry;
  logic fault;
  logic overcurrent;
  logic supply_overvolt;
  logic bus_voltage_floor;
  logic back_voltage;
  logic discharge_err;
  logic thermal_high_limit;
  logic thermal_low_limit;
  logic constant_current_mode;

  modport rec (input port_power_request, input in_error, input latch_sel,
    input err_clear, output retry);
  modport cls (input port_power_request, input overcurrent, input supply_overvolt,
    input bus_voltage_floor, input back_voltage, input discharge_err,
    input thermal_high_limit, input thermal_low_limit, input constant_current_mode,
    output fault);
endinterface

// ### hw/crf_fault_class.sv
// Fault classifier for one port
`timescale 1ns/100ps
module crf_fault_class
  import crf_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  crf_port_if.cls pif
);
  typedef struct packed {
    logic fault;
    logic prev_req;
    logic booted;
  } crf_cls_t;

  crf_cls_t st;
  crf_cls_t next_st;
  logic req_rise;
  logic powerup_req;

  always_comb
  begin
    next_st = st;
    req_rise = pif.port_power_request && !st.prev_req;
    powerup_req = !st.booted && pif.port_power_request;
    next_st.prev_req = pif.port_power_request;
    next_st.booted = 1'b1;
    // Other keep-out cases and low-limit heat on a plain closed or open switch are no fault
    next_st.fault = pif.overcurrent || pif.supply_overvolt || pif.bus_voltage_floor
      || pif.back_voltage || pif.discharge_err || pif.thermal_high_limit;
    if (pif.thermal_low_limit && (pif.constant_current_mode || req_rise || powerup_req))
    begin
      next_st.fault = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pif.fault = st.fault;
endmodule

// ### hw/crf_recover.sv
// Error recovery sequencer for one port: timed or host-requested retest
`timescale 1ns/100ps
module crf_recover
  import crf_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  crf_port_if.rec pif
);
  typedef struct packed {
    logic [CYC_W-1:0] cnt;
    logic retry;
    logic prev_req;
  } crf_rec_t;

  crf_rec_t st;
  crf_rec_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.retry = 1'b0;
    next_st.prev_req = pif.port_power_request;
    if (!pif.in_error)
    begin
      next_st.cnt = '0;
    end
    else if (pif.latch_sel)
    begin
      // One retest per enable fall or error clear
      next_st.cnt = '0;
      next_st.retry = (st.prev_req && !pif.port_power_request) || pif.err_clear;
    end
    else if (st.cnt == CYC_W'(T_CYCLE_CYC - 1))
    begin
      next_st.cnt = '0;
      next_st.retry = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + CYC_W'(1);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pif.retry = st.retry;
endmodule

// ### hw/crf_top.sv
// Charge rationing and fault control for two switch ports, with APB registers
`timescale 1ns/100ps
module crf_top
  import crf_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [1:0] I_PORT_POWER_REQUEST,
  input wire logic [1:0] I_CHARGE_TICK,
  input wire logic [1:0] I_OVERCURRENT,
  input wire logic [1:0] I_BUS_VOLTAGE_FLOOR,
  input wire logic [1:0] I_BACK_VOLTAGE,
  input wire logic [1:0] I_DISCHARGE_ERR,
  input wire logic [1:0] I_CONSTANT_CURRENT_MODE,
  input wire logic I_SUPPLY_OVERVOLT,
  input wire logic I_THERMAL_HIGH_LIMIT,
  input wire logic I_THERMAL_LOW_LIMIT,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  output logic [1:0] O_ALERT_N,
  output logic [1:0] O_SWITCH_CLOSE,
  output logic [1:0] O_MONITOR_EN,
  output logic [1:0] O_THRESH_EVENT,
  output logic [1:0] O_IN_ERROR
);
  typedef struct packed {
    logic [CW-1:0] charge;
    logic reached_flag_a;
    crf_pst_t pst;
  } crf_port_t;

  typedef struct packed {
    crf_port_t [1:0] p;
    logic [1:0] reached_flag_a_enable_ctl;
    crf_act_t [1:0] reached_flag_a_action_sel;
    logic latch_sel;
    logic [1:0][CW-1:0] thr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] alert_n;
    logic [1:0] sw;
    logic [1:0] mon;
    logic [1:0] event_p;
    logic [1:0] in_err;
  } crf_top_t;

  crf_top_t st;
  crf_top_t next_st;

  logic acc;
  logic wr;
  logic [1:0] rst_now;
  logic [1:0] eclr_now;
  logic [1:0] fault_v;
  logic [1:0] retry_v;
  logic [1:0] hold;
  logic [1:0] blk;
  logic [1:0] ralert;
  logic [1:0] req;

  function automatic logic f_mapped(input logic [7:0] a);
    return (a == A_CTRL) || (a == A_CMD) || (a == A_STAT) || (a == A_THR1)
      || (a == A_THR2) || (a == A_CHG);
  endfunction

  crf_port_if pif[2] ();

  for (genvar g = 0; g < 2; g++)
  begin : g_link
    assign pif[g].port_power_request = I_PORT_POWER_REQUEST[g];
    assign pif[g].in_error = (st.p[g].pst == ST_ERROR);
    assign pif[g].latch_sel = st.latch_sel;
    assign pif[g].err_clear = eclr_now[g];
    assign pif[g].overcurrent = I_OVERCURRENT[g];
    assign pif[g].supply_overvolt = I_SUPPLY_OVERVOLT;
    assign pif[g].bus_voltage_floor = I_BUS_VOLTAGE_FLOOR[g];
    assign pif[g].back_voltage = I_BACK_VOLTAGE[g];
    assign pif[g].discharge_err = I_DISCHARGE_ERR[g];
    assign pif[g].thermal_high_limit = I_THERMAL_HIGH_LIMIT;
    assign pif[g].thermal_low_limit = I_THERMAL_LOW_LIMIT;
    assign pif[g].constant_current_mode = I_CONSTANT_CURRENT_MODE[g];
    assign fault_v[g] = pif[g].fault;
    assign retry_v[g] = pif[g].retry;

    crf_fault_class u_cls (
      .i_clock(I_CLOCK),
      .i_rst(I_RST),
      .pif(pif[g])
    );

    crf_recover u_rec (
      .i_clock(I_CLOCK),
      .i_rst(I_RST),
      .pif(pif[g])
    );
  end

  // Bus decode: read data prepared in first access cycle, writes land with pready
  assign acc = I_PSEL && I_PENABLE && !st.pready;
  assign wr = I_PSEL && I_PENABLE && st.pready && I_PWRITE;
  assign rst_now = (wr && I_PADDR == A_CMD) ? I_PWDATA[CMD_RST_LSB +: 2] : 2'h0;
  assign eclr_now = (wr && I_PADDR == A_CMD) ? I_PWDATA[CMD_ECLR_LSB +: 2] : 2'h0;
  assign req = I_PORT_POWER_REQUEST;

  always_comb
  begin
    next_st = st;
    hold = 2'h0;
    blk = 2'h0;
    ralert = 2'h0;
    next_st.pready = acc;
    next_st.pslverr = acc && !f_mapped(I_PADDR);
    next_st.prdata = 32'h0;
    if (acc && !I_PWRITE)
    begin
      case (I_PADDR)
        A_CTRL: next_st.prdata = {25'h0, st.latch_sel, st.reached_flag_a_action_sel,
          st.reached_flag_a_enable_ctl};
        A_STAT: next_st.prdata = {22'h0, ~st.alert_n, st.sw, st.p[1].pst, st.p[0].pst,
          st.p[1].reached_flag_a, st.p[0].reached_flag_a};
        A_THR1: next_st.prdata = {16'h0, st.thr[0]};
        A_THR2: next_st.prdata = {16'h0, st.thr[1]};
        A_CHG: next_st.prdata = {st.p[1].charge, st.p[0].charge};
        default: next_st.prdata = 32'h0;
      endcase
    end
    if (wr)
    begin
      case (I_PADDR)
        A_CTRL:
        begin
          // Only the control bits move; clearing a port's enable bit also zeroes its charge and flag
          next_st.reached_flag_a_enable_ctl = I_PWDATA[CTRL_EN_LSB +: 2];
          next_st.reached_flag_a_action_sel[0] = crf_act_t'(I_PWDATA[CTRL_ACT_LSB +: 2]);
          next_st.reached_flag_a_action_sel[1] = crf_act_t'(I_PWDATA[CTRL_ACT_LSB + 2 +: 2]);
          next_st.latch_sel = I_PWDATA[CTRL_LATCH];
        end
        A_THR1: next_st.thr[0] = I_PWDATA[CW-1:0];
        A_THR2: next_st.thr[1] = I_PWDATA[CW-1:0];
        default: next_st.thr = st.thr;
      endcase
    end
    for (int i = 0; i < 2; i++)
    begin
      next_st.event_p[i] = 1'b0;
      if (!next_st.reached_flag_a_enable_ctl[i] || rst_now[i])
      begin
        next_st.p[i].charge = '0;
        next_st.p[i].reached_flag_a = 1'b0;
      end
      else if (st.p[i].pst == ST_ACTIVE && I_CHARGE_TICK[i] && st.p[i].charge != '1)
      begin
        next_st.p[i].charge = st.p[i].charge + CW'(1);
      end
      // Crossing seen the cycle a reset lands still sets the flag
      if (next_st.reached_flag_a_enable_ctl[i] && st.p[i].pst == ST_ACTIVE
        && !st.p[i].reached_flag_a && st.p[i].charge >= next_st.thr[i])
      begin
        next_st.p[i].reached_flag_a = 1'b1;
        next_st.event_p[i] = 1'b1;
      end
      // Mode effects come from current selection, so later changes act at once
      ralert[i] = next_st.p[i].reached_flag_a && next_st.reached_flag_a_enable_ctl[i]
        && f_alerts(next_st.reached_flag_a_action_sel[i]);
      blk[i] = next_st.p[i].reached_flag_a && next_st.reached_flag_a_enable_ctl[i]
        && f_blocks(next_st.reached_flag_a_action_sel[i]);
      hold[i] = next_st.p[i].reached_flag_a && next_st.reached_flag_a_enable_ctl[i]
        && next_st.reached_flag_a_action_sel[i] == ACT_DISSLEEP;
      case (st.p[i].pst)
        ST_ACTIVE:
        begin
          if (fault_v[i])
          begin
            next_st.p[i].pst = ST_ERROR;
          end
          else if (hold[i])
          begin
            next_st.p[i].pst = ST_RSLEEP;
          end
          else if (!req[i])
          begin
            next_st.p[i].pst = ST_SLEEP;
          end
        end
        ST_SLEEP:
        begin
          if (hold[i])
          begin
            next_st.p[i].pst = ST_RSLEEP;
          end
          else if (req[i])
          begin
            next_st.p[i].pst = ST_ACTIVE;
          end
        end
        ST_RSLEEP:
        begin
          // Enables ignored until reset, disable or mode change
          if (!hold[i])
          begin
            next_st.p[i].pst = req[i] ? ST_ACTIVE : ST_SLEEP;
          end
        end
        ST_ERROR:
        begin
          if (retry_v[i] && !fault_v[i])
          begin
            next_st.p[i].pst = req[i] ? ST_ACTIVE : ST_SLEEP;
          end
        end
        default: next_st.p[i].pst = ST_SLEEP;
      endcase
      next_st.sw[i] = next_st.p[i].pst == ST_ACTIVE && !blk[i];
      next_st.alert_n[i] = !(ralert[i] || next_st.p[i].pst == ST_ERROR);
      next_st.mon[i] = next_st.p[i].pst != ST_RSLEEP;
      next_st.in_err[i] = next_st.p[i].pst == ST_ERROR;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      st <= '0;
      st.reached_flag_a_action_sel[0] <= ACT_RST;
      st.reached_flag_a_action_sel[1] <= ACT_RST;
      st.thr <= {THR_RST, THR_RST};
      st.alert_n <= 2'h3;
      st.mon <= 2'h3;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign O_PREADY = st.pready;
  assign O_PRDATA = st.prdata;
  assign O_PSLVERR = st.pslverr;
  assign O_ALERT_N = st.alert_n;
  assign O_SWITCH_CLOSE = st.sw;
  assign O_MONITOR_EN = st.mon;
  assign O_THRESH_EVENT = st.event_p;
  assign O_IN_ERROR = st.in_err;

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);

  for (genvar k = 0; k < 2; k++)
  begin : g_chk
    sequence s_err_enter;
      $rose(st.p[k].pst == ST_ERROR) && !st.latch_sel;
    endsequence

    property p_err_wait;
      s_err_enter |-> (st.p[k].pst == ST_ERROR)[*8];
    endproperty

    // Reset not coinciding with a fresh crossing, where the set wins
    sequence s_rst_after;
      rst_now[k] && st.reached_flag_a_enable_ctl[k] && (st.p[k].reached_flag_a
        || st.p[k].pst != ST_ACTIVE || st.p[k].charge < st.thr[k]);
    endsequence

    a_switch_blocked: assert property (
      (st.p[k].reached_flag_a && st.reached_flag_a_enable_ctl[k]
        && st.reached_flag_a_action_sel[k] == ACT_REPDIS) |-> !O_SWITCH_CLOSE[k])
      else $error("switch closed while rationing holds it open");

    a_alert_report: assert property (
      (st.p[k].reached_flag_a && st.reached_flag_a_enable_ctl[k]
        && st.reached_flag_a_action_sel[k] == ACT_REPORT) |-> !O_ALERT_N[k])
      else $error("report mode without alert");

    a_ignore_quiet: assert property (
      (st.reached_flag_a_action_sel[k] == ACT_IGNORE && st.p[k].pst != ST_ERROR)
        |-> O_ALERT_N[k])
      else $error("alert asserted in ignore mode");

    a_sleep_lock: assert property (
      (st.p[k].pst == ST_RSLEEP && st.reached_flag_a_action_sel[k] == ACT_DISSLEEP
        && !wr) |=> st.p[k].pst == ST_RSLEEP)
      else $error("reached_flag_a sleep left without reset or change");

    a_monitor_gate: assert property (
      O_MONITOR_EN[k] == (st.p[k].pst != ST_RSLEEP))
      else $error("monitor enable does not match power state");

    a_event_once: assert property (
      O_THRESH_EVENT[k] |-> st.p[k].reached_flag_a && !$past(st.p[k].reached_flag_a))
      else $error("threshold event not on first reach");

    a_reset_clear: assert property (
      s_rst_after |=> st.p[k].charge == '0
        && !st.p[k].reached_flag_a)
      else $error("reached_flag_a reset left charge or flag");

    a_disable_clear: assert property (
      !st.reached_flag_a_enable_ctl[k] |-> st.p[k].charge == '0 && !st.p[k].reached_flag_a)
      else $error("charge kept while rationing disabled");

    a_inactive_hold: assert property (
      (st.p[k].pst != ST_ACTIVE && st.reached_flag_a_enable_ctl[k] && !rst_now[k]
        && !wr) |=> $stable(st.p[k].charge) && !O_THRESH_EVENT[k])
      else $error("rationing acted outside active state");

    a_err_wait: assert property (p_err_wait)
      else $error("auto recovery left error too soon");

    a_latch_wait: assert property (
      (st.p[k].pst == ST_ERROR && st.latch_sel && !retry_v[k])
        |=> st.p[k].pst == ST_ERROR)
      else $error("latched error left without request");

    a_fault_entry: assert property (
      (st.p[k].pst == ST_ACTIVE && fault_v[k]) |=> st.p[k].pst == ST_ERROR
        && !O_ALERT_N[k] && !O_SWITCH_CLOSE[k])
      else $error("fault in active state did not enter error");
  end
endmodule

// ### tb/crf_host.sv
// Host model driving the per-port power enable lines
`timescale 1ns/100ps
module crf_host
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [1:0] i_want,
  output logic [1:0] o_req
);
  // Enables move only just after an edge; a toggle asks for a retest
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_req <= 2'h0;
    end
    else
    begin
      o_req <= i_want;
    end
  end
endmodule

// ### tb/charge_reached_flag_a_fault_control_tb.sv
// Self-checking bench for the rationing and fault control block
`timescale 1ns/100ps
module charge_reached_flag_a_fault_control_tb;
  import crf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] want = 2'h0;
  logic [1:0] tck = 2'h0;
  logic [1:0] cc = 2'h0;
  logic [6:0] flt = 7'h00;
  logic [1:0] req, alert_n, sw, mon, ev, in_err;
  logic pready, pslverr, rerr;
  logic [31:0] prdata, rdata;
  int error_cnt = 0;
  int n_checks = 0;
  int ev_cnt = 0;
  int thr, e0;

  always #2.5 clk = ~clk;
  always @(posedge clk) ev_cnt <= ev_cnt + int'(ev[0] === 1'b1);

  crf_host u_crf_host (.i_clock(clk), .i_rst(rst), .i_want(want), .o_req(req));

  crf_top u_crf_top (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PORT_POWER_REQUEST(req),
    .I_CHARGE_TICK(tck), .I_OVERCURRENT({1'b0, flt[0]}),
    .I_BUS_VOLTAGE_FLOOR({1'b0, flt[1]}), .I_BACK_VOLTAGE({1'b0, flt[2]}),
    .I_DISCHARGE_ERR({1'b0, flt[3]}), .I_CONSTANT_CURRENT_MODE(cc),
    .I_SUPPLY_OVERVOLT(flt[4]), .I_THERMAL_HIGH_LIMIT(flt[5]),
    .I_THERMAL_LOW_LIMIT(flt[6]), .O_PREADY(pready), .O_PRDATA(prdata),
    .O_PSLVERR(pslverr), .O_ALERT_N(alert_n), .O_SWITCH_CLOSE(sw),
    .O_MONITOR_EN(mon), .O_THRESH_EVENT(ev), .O_IN_ERROR(in_err));

  task summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Hang is ended by the watchdog only
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task pulse(input int n);
    tck[0] <= 1'b1;
    cyc(n);
    tck[0] <= 1'b0;
    cyc(4);
  endtask

  // Expected {alert_n, switch, monitor} of port 1
  function automatic logic [2:0] model(input int act, input bit rch, input bit rq);
    if (rch && act == 2)
      return 3'b100;
    return {~(rch && act < 2), rq && !(rch && act == 1), 1'b1};
  endfunction

  task pins(input int act, input bit rch, input bit rq);
    chk("port1 pins", 32'(model(act, rch, rq)), {29'h0, alert_n[0], sw[0], mon[0]});
    chk("port2 pins", 32'(model(0, 0, 0)), {29'h0, alert_n[1], sw[1], mon[1]});
  endtask

  task wait_clear(input int lim);
    int n;
    n = 0;
    while (in_err[0] !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk("in error", 32'h0, 32'(in_err[0]));
  endtask

  initial
  begin
    #300000;
    error_cnt++;
    summarize();
  end

  initial
  begin
    void'($urandom(2));
    thr = 3 + $urandom % 6;
    cyc(8);
    rst <= 1'b0;
    want <= 2'h1;
    cyc(3);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl", 32'h14, rdata);
    apb(1'b0, A_THR1, 32'h0);
    chk("thr1", {16'h0, THR_RST}, rdata);
    apb(1'b0, 8'hFC, 32'h0);
    chk("slverr", 32'h1, 32'(rerr));
    apb(1'b1, A_THR1, 32'(thr));
    want <= 2'h0;
    cyc(3);
    apb(1'b1, A_CTRL, 32'h15);
    pulse(thr + 2);
    apb(1'b0, A_STAT, 32'h0);
    chk("reached", 32'h0, 32'(rdata[0]));
    want <= 2'h1;
    cyc(3);
    pulse(thr - 1);
    apb(1'b1, A_CMD, 32'h1);
    pulse(thr - 1);
    apb(1'b0, A_CHG, 32'h0);
    chk("charge", 32'(thr - 1), 32'(rdata[15:0]));
    pins(1, 0, 1);
    apb(1'b1, A_CTRL, 32'h14);
    apb(1'b0, A_CHG, 32'h0);
    chk("charge", 32'h0, rdata);
    for (int p = 0; p < 4; p++)
      for (int q = 0; q < 4; q++)
      begin
        e0 = ev_cnt;
        apb(1'b1, A_CTRL, 32'h1 | (32'(p) << 2));
        pulse(thr);
        pins(p, 1, 1);
        chk("events", 32'(e0 + 1), 32'(ev_cnt));
        apb(1'b1, A_CTRL, 32'h1 | (32'(q) << 2));
        cyc(2);
        pins(q, 1, 1);
        apb(1'b0, A_CHG, 32'h0);
        chk("charge", 32'(thr), 32'(rdata[15:0]));
        want <= 2'h0;
        cyc(4);
        pins(q, 1, 0);
        want <= 2'h1;
        cyc(4);
        pins(q, 1, 1);
        if ((p + q) % 2 == 1)
          apb(1'b1, A_CMD, 32'h1);
        else
          apb(1'b1, A_CTRL, 32'(q) << 2);
        cyc(3);
        pins(q, 0, 1);
        apb(1'b0, A_STAT, 32'h0);
        chk("reached", 32'h0, 32'(rdata[0]));
        apb(1'b0, A_CHG, 32'h0);
        chk("charge", 32'h0, rdata);
      end
    apb(1'b1, A_CTRL, 32'h14);
    for (int k = 0; k < 7; k++)
    begin
      flt <= 7'(1 << k);
      cc[0] <= (k == 6);
      cyc(4);
      chk("in error", 32'h1, 32'(in_err[0]));
      chk("alert", 32'h0, 32'(alert_n[0]));
      flt <= 7'h00;
      cc <= 2'h0;
      cyc(100);
      chk("in error", 32'h1, 32'(in_err[0]));
      wait_clear(400);
    end
    flt <= 7'h40;
    cyc(6);
    chk("in error", 32'h0, 32'(in_err[0]));
    want <= 2'h0;
    cyc(3);
    want <= 2'h1;
    cyc(5);
    chk("in error", 32'h1, 32'(in_err[0]));
    flt <= 7'h00;
    wait_clear(400);
    apb(1'b1, A_CTRL, 32'h54);
    flt <= 7'h01;
    cyc(4);
    flt <= 7'h00;
    cyc(300);
    chk("in error", 32'h1, 32'(in_err[0]));
    want <= 2'h0;
    cyc(2);
    want <= 2'h1;
    wait_clear(20);
    cyc(3);
    flt <= 7'h01;
    cyc(4);
    flt <= 7'h00;
    cyc(2);
    apb(1'b1, A_CMD, 32'h4);
    wait_clear(20);
    chk("port2 idle", 32'h0, {30'h0, in_err[1], ev[1]});
    summarize();
  end
endmodule
